// File: shared/rwr_pkg.sv
// Package for the register window remapper: register offsets, window geometry,
// reset values and the bus and core-side carrier structs.
// Assumes a 16-bit physical register space and an AXI4-Lite control bus.
package rwr_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Printed offsets are not all multiples of four, so they are indices.
    localparam logic [7:0]  RWR_IDX_ZERO       = 8'h00;
    localparam logic [7:0]  RWR_IDX_PRIMARY    = 8'h14;
    localparam logic [7:0]  RWR_IDX_SECONDARY  = 8'h15;
    localparam logic [7:0]  RWR_IDX_STATUS     = 8'h20;
    localparam logic [7:0]  RWR_RST_PRIMARY    = 8'h00;
    localparam logic [7:0]  RWR_RST_SECONDARY  = 8'h00;
    localparam logic [15:0] RWR_ZERO_VALUE     = 16'h0000;
    localparam int          RWR_HOLD_BIT       = 7;
    localparam int          RWR_RSVD_BIT       = 7;

    // ------------------------------------------------------------------
    // Window geometry
    // ------------------------------------------------------------------
    localparam logic [15:0] RWR_P32_BASE  = 16'h00e0;
    localparam logic [15:0] RWR_P64_BASE  = 16'h00c0;
    localparam logic [15:0] RWR_P128_BASE = 16'h0080;
    localparam logic [15:0] RWR_S32_BASE  = 16'h0060;
    localparam logic [15:0] RWR_S64_BASE  = 16'h0040;
    localparam logic [15:0] RWR_LOWER_TOP = 16'h00ff;
    // Windowed segments sit in the special-function page; the upper file is not reachable.
    localparam logic [15:0] RWR_SEG_OFFSET = 16'h1000;

    typedef enum logic [1:0] {
        RWR_SZ_NONE,
        RWR_SZ_32,
        RWR_SZ_64,
        RWR_SZ_128
    } rwr_size_t;

    // Core-side request toward the remapper.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rwr_core_req_t;

    // Remapped request toward the register file and peripherals.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        zero_hit;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rwr_phys_req_t;

endpackage : rwr_pkg

// File: rtl/rwr_window_decode.sv
// Window decoder: turns a window select value into size and segment base and
// tests a direct address against that window.
// Assumes the select value is stable while an access is being decoded.
`timescale 1ns/1ns
module rwr_window_decode
    import rwr_pkg::*;
#(
    parameter bit SECONDARY = 1'b0
) (
    input  wire logic [6:0]  sel,
    input  wire logic [15:0] dir_addr,
    output      rwr_size_t   size,
    output      logic        hit,
    output      logic [15:0] phys_addr
);

    // ------------------------------------------------------------------
    // Size from the top set bit of the seven-bit window number field
    // ------------------------------------------------------------------
    // Secondary window offers only 32 and 64 bytes; a 128-byte code is off.
    wire sz32  = sel[6];
    wire sz64  = !sel[6] && sel[5];
    wire sz128 = !sel[6] && !sel[5] && sel[4] && !SECONDARY;

    assign size = sz32 ? RWR_SZ_32 : sz64 ? RWR_SZ_64 : sz128 ? RWR_SZ_128 : RWR_SZ_NONE;

    // ------------------------------------------------------------------
    // Window base in the lower file and physical segment number
    // ------------------------------------------------------------------
    wire [15:0] win_base = SECONDARY ? (sz32 ? RWR_S32_BASE : RWR_S64_BASE)
                                     : (sz32 ? RWR_P32_BASE : sz64 ? RWR_P64_BASE : RWR_P128_BASE);
    wire [15:0] win_mask = sz32 ? 16'h001f : sz64 ? 16'h003f : 16'h007f;
    // Segment number times the window length, lifted into the special-function page,
    // gives the physical base.
    wire [15:0] seg_base = RWR_SEG_OFFSET | (sz32 ? {4'h0, sel[6:0], 5'h00}
                                           : sz64 ? {4'h0, sel[5:0], 6'h00}
                                           :        {4'h0, sel[4:0], 7'h00});

    assign hit       = (size != RWR_SZ_NONE) && ((dir_addr & ~win_mask) == win_base);
    assign phys_addr = seg_base | (dir_addr & win_mask);

endmodule : rwr_window_decode

// File: rtl/rwr_top.sv
// Register window remapper top: AXI4-Lite window registers plus the core-side
// direct address remapping path toward register file and peripherals.
// Assumes the core and bus share aclk and the far side answers in the same cycle.
//
// Function
// - Secondary window maps a 32/64-byte segment into the middle, below primary.
// - Seven low secondary select bits give window size and window number.
// - 7DH/32 or 3EH/64 maps serial status 1FB9H to direct 0079H.
// - 7CH/32 maps timer-1 control 1F90H to 0070H; 3EH/64 to 0050H.
// - Primary 7DH/3EH map PWM-0 control 1FB0H to 00F0H; 1FH to 00B0H.
// - Primary 7EH maps port-4 pin 1FDFH to 00FFH; 3FH/1FH to 00DFH.
// - Direct address 00H is a 16-bit register that always reads zero.
// - Primary window maps 32, 64 or 128 bytes into top of lower file.
// - Bus-hold enable bit has no effect on window selection or remapping.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module rwr_top
    import rwr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output      logic          s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output      logic          s_axi_wready,
    output      logic [1:0]    s_axi_bresp,
    output      logic          s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output      logic          s_axi_arready,
    output      logic [31:0]   s_axi_rdata,
    output      logic [1:0]    s_axi_rresp,
    output      logic          s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire rwr_core_req_t core_req,
    output      logic [15:0]   core_rdata,
    output      rwr_phys_req_t phys_req,
    input  wire logic [15:0]   phys_rdata,
    output      logic          bus_hold_enable
);

    initial begin
        if (ADDR_W < 10) $error("ADDR_W must reach the register indices.");
    end

    // ------------------------------------------------------------------
    // Window select registers
    // ------------------------------------------------------------------
    logic [7:0]  primary_window_select_q;
    logic [7:0]  secondary_window_select_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic        aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        w_held_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // ------------------------------------------------------------------
    // AXI4-Lite write path: address and data are latched independently
    // ------------------------------------------------------------------
    // Only one write is accepted until its response has been taken.
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    wire [ADDR_W-1:0] wr_addr  = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0]       wr_data  = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0]        wr_strb  = w_held_q ? wstrb_q : s_axi_wstrb;
    wire              wr_go    = (aw_held_q || aw_fire) && (w_held_q || w_fire);
    wire [ADDR_W-3:0] wr_idx   = wr_addr[ADDR_W-1:2];
    wire hit_w_pr = wr_idx == (ADDR_W-2)'(RWR_IDX_PRIMARY);
    wire hit_w_sc = wr_idx == (ADDR_W-2)'(RWR_IDX_SECONDARY);
    wire hit_w_z  = wr_idx == (ADDR_W-2)'(RWR_IDX_ZERO);
    wire wr_known = hit_w_pr || hit_w_sc || hit_w_z || wr_idx == (ADDR_W-2)'(RWR_IDX_STATUS);

    // Handshake bookkeeping for the write channels.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'b00;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (aw_fire) awaddr_q <= s_axi_awaddr;
            if (w_fire) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_held_q <= wr_go ? 1'b0 : (aw_held_q || aw_fire);
            w_held_q  <= wr_go ? 1'b0 : (w_held_q || w_fire);
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_known ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Register updates; the zero word ignores writes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primary_window_select_q   <= RWR_RST_PRIMARY;
            secondary_window_select_q <= RWR_RST_SECONDARY;
        end else if (wr_go && wr_strb[0]) begin
            if (hit_w_pr) primary_window_select_q <= wr_data[7:0];
            // The reserved top bit is stored as written; it never steers decode.
            if (hit_w_sc) secondary_window_select_q <= wr_data[7:0];
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    wire              ar_fire = s_axi_arvalid && s_axi_arready;
    wire [ADDR_W-3:0] rd_idx  = s_axi_araddr[ADDR_W-1:2];
    wire hit_r_z  = rd_idx == (ADDR_W-2)'(RWR_IDX_ZERO);
    wire hit_r_pr = rd_idx == (ADDR_W-2)'(RWR_IDX_PRIMARY);
    wire hit_r_sc = rd_idx == (ADDR_W-2)'(RWR_IDX_SECONDARY);
    wire hit_r_st = rd_idx == (ADDR_W-2)'(RWR_IDX_STATUS);

    rwr_size_t   prim_size;
    rwr_size_t   sec_size;
    logic        prim_hit;
    logic        sec_hit;
    logic [15:0] prim_phys;
    logic [15:0] sec_phys;

    // Status word shows the decoded sizes of both windows.
    wire [31:0] status_word = {28'h000_0000, sec_size, prim_size};
    wire [31:0] rd_mux = hit_r_z  ? {16'h0000, RWR_ZERO_VALUE}
                       : hit_r_pr ? {24'h00_0000, primary_window_select_q}
                       : hit_r_sc ? {24'h00_0000, secondary_window_select_q}
                       : hit_r_st ? status_word
                       :            32'h0000_0000;
    wire rd_known = hit_r_z || hit_r_pr || hit_r_sc || hit_r_st;

    // Read answer is registered one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'b00;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_known ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ------------------------------------------------------------------
    // Window decoders
    // ------------------------------------------------------------------
    // Primary decode looks at bits 6:0 only, so bus-hold enable cannot steer it.
    rwr_window_decode #(.SECONDARY(1'b0)) u_primary (
        .sel       (primary_window_select_q[6:0]),
        .dir_addr  (core_req.addr),
        .size      (prim_size),
        .hit       (prim_hit),
        .phys_addr (prim_phys)
    );

    // The secondary select has its own window number field in bits 6:0.
    rwr_window_decode #(.SECONDARY(1'b1)) u_secondary (
        .sel       (secondary_window_select_q[6:0]),
        .dir_addr  (core_req.addr),
        .size      (sec_size),
        .hit       (sec_hit),
        .phys_addr (sec_phys)
    );

    assign bus_hold_enable = primary_window_select_q[RWR_HOLD_BIT];

    // ------------------------------------------------------------------
    // Core-side remap
    // ------------------------------------------------------------------
    // Word accesses to flagged registers stay whole because the remap keeps bit 0.
    // A 128-byte primary window starts at 80H, just above the secondary range; the primary is checked first.
    wire zero_hit = core_req.addr[15:1] == 15'h0000;
    wire [15:0] remap = prim_hit ? prim_phys : sec_hit ? sec_phys : core_req.addr;

    assign phys_req.valid    = core_req.valid;
    assign phys_req.write    = core_req.write && !zero_hit;
    assign phys_req.zero_hit = zero_hit;
    assign phys_req.addr     = remap;
    assign phys_req.wdata    = core_req.wdata;
    assign core_rdata        = zero_hit ? RWR_ZERO_VALUE : phys_rdata;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    zero_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        zero_hit |-> core_rdata == 16'h0000) else $error("Zero word read nonzero.");
    zero_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        zero_hit |-> !phys_req.write) else $error("Write reached the zero word.");
    pass_through_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (core_req.addr[15:8] != 8'h00) |-> phys_req.addr == core_req.addr) else $error("Upper address remapped.");
    serial_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (secondary_window_select_q[6:0] == 7'h7d && !prim_hit
         && core_req.addr == 16'h0079) |-> phys_req.addr == 16'h1fb9) else $error("Serial status remap wrong.");
    timer_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (secondary_window_select_q[6:0] == 7'h3e && !prim_hit
         && core_req.addr == 16'h0050) |-> phys_req.addr == 16'h1f90) else $error("Timer control remap wrong.");
    pwm_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (primary_window_select_q[6:0] == 7'h1f && core_req.addr == 16'h00b0)
        |-> phys_req.addr == 16'h1fb0) else $error("PWM control remap wrong.");
    port_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (primary_window_select_q[6:0] == 7'h7e && core_req.addr == 16'h00ff)
        |-> phys_req.addr == 16'h1fdf) else $error("Port pin remap wrong.");
    hold_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(bus_hold_enable) && $stable(primary_window_select_q[6:0]) |-> $stable(prim_size))
        else $error("Bus-hold bit changed window size.");
    sec_size_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sec_size != RWR_SZ_128) else $error("Secondary window took 128 bytes.");
    sec_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_strb[0] && hit_w_sc |=> secondary_window_select_q == $past(wr_data[7:0]))
        else $error("Secondary select not updated.");
    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_fire |=> s_axi_rvalid) else $error("Read answer late.");

    sec_used_c:  cover property (@(posedge aclk) disable iff (!aresetn) sec_hit && core_req.valid);
    prim_used_c: cover property (@(posedge aclk) disable iff (!aresetn) prim_hit && core_req.valid);
    zero_wr_c:   cover property (@(posedge aclk) disable iff (!aresetn) zero_hit && core_req.write);

endmodule : rwr_top

// File: sim/rwr_phys_model.sv
// Far-side model of the register file and peripherals behind the remapper.
// Assumes phys_req is combinational from the core request and answered in-cycle.
`timescale 1ns/1ns
module rwr_phys_model
    import rwr_pkg::*;
(
    input  wire logic          aclk,
    input  wire rwr_phys_req_t phys_req,
    output      logic [15:0]   phys_rdata
);
    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [15:0] last_q = 16'h0000;

    // Every location answers with a word derived from its address, so a wrong remap shows.
    // Answers are whole words only; byte lanes are never split.
    // An idle bus shows the inverse of the last word, so a stale value never passes.
    assign phys_rdata = phys_req.valid ? (phys_req.addr ^ 16'h5a5a) : ~last_q;

    // Remember the last word driven.
    always_ff @(posedge aclk) begin
        last_q <= phys_rdata;
    end
endmodule : rwr_phys_model

// File: sim/test_register_window_remapper.sv
// Self-checking bench for the register window remapper top.
// Assumes the far-side model answers in the same cycle and AXI4-Lite answers come in time.
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module test_register_window_remapper;
    import rwr_pkg::*;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic [11:0]   awaddr = '0, araddr = '0;
    logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0]   wdata = '0, rdata;
    logic [3:0]    wstrb = 4'hf;
    logic          awready, wready, bvalid, arready, rvalid, hold;
    logic [1:0]    bresp, rresp;
    rwr_core_req_t core_req = '0;
    rwr_phys_req_t phys_req;
    logic [15:0]   core_rdata, phys_rdata;
    int            num_errors = 0;
    int            samples_checked = 0;

    rwr_top rwr_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_req(core_req),
        .core_rdata(core_rdata), .phys_req(phys_req), .phys_rdata(phys_rdata), .bus_hold_enable(hold));
    rwr_phys_model rwr_phys_model_inst (.aclk(aclk), .phys_req(phys_req), .phys_rdata(phys_rdata));

    // Clock at 25 MHz.
    initial begin
        forever #20 aclk = ~aclk;
    end

    // ------------------------------------------------------------------
    // Bus and core tasks
    // ------------------------------------------------------------------
    // Readies are looked at on the falling edge, where they are settled, and acted on at the next rise.
    // The tasks wait as long as the answer takes; only the watchdog ends a hang.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = arvalid && arready; d = rdata; r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (rvalid && !ta && !arvalid) begin
                rready <= 1'b0;
                return;
            end
        end
    endtask : axi_rd

    // One core access; the remapped request and the read data are judged in the same cycle.
    task automatic core_chk(input logic [15:0] dir, input logic wr, input logic [15:0] ea, input logic ez);
        @(posedge aclk);
        core_req <= '{1'b1, wr, dir, 16'h1234};
        @(negedge aclk);
        `CHK(phys_req.valid, 1'b1)
        `CHK(phys_req.zero_hit, ez)
        `CHK(phys_req.write, wr & ~ez)
        `CHK(phys_req.wdata, 16'h1234)
        if (!ez) `CHK(phys_req.addr, ea)
        `CHK(core_rdata, ez ? 16'h0000 : (ea ^ 16'h5a5a))
    endtask : core_chk

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_state();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(12'h050, d, r); `CHK(d, 32'h0)
        axi_rd(12'h054, d, r); `CHK(d, 32'h0)
        `CHK(hold, 1'b0)
        core_chk(16'h00f0, 1'b0, 16'h00f0, 1'b0);
        core_chk(16'h0079, 1'b0, 16'h0079, 1'b0);
    endtask : test_reset_state

    // Columns: register byte address, select value, direct address, physical address, address just outside.
    // The seventh row flips only the bus-hold bit of the sixth, so the window must not move.
    task automatic test_windows();
        logic [15:0] t [11][5] = '{
            '{16'h0050, 16'h007d, 16'h00f0, 16'h1fb0, 16'h00df}, '{16'h0050, 16'h003e, 16'h00f0, 16'h1fb0, 16'h00bf},
            '{16'h0050, 16'h001f, 16'h00b0, 16'h1fb0, 16'h007f}, '{16'h0050, 16'h007e, 16'h00ff, 16'h1fdf, 16'h00df},
            '{16'h0050, 16'h003f, 16'h00df, 16'h1fdf, 16'h00bf}, '{16'h0050, 16'h007d, 16'h00f0, 16'h1fb0, 16'h00df},
            '{16'h0050, 16'h00fd, 16'h00f0, 16'h1fb0, 16'h00df},
            '{16'h0054, 16'h007d, 16'h0079, 16'h1fb9, 16'h005f}, '{16'h0054, 16'h003e, 16'h0079, 16'h1fb9, 16'h003f},
            '{16'h0054, 16'h007c, 16'h0070, 16'h1f90, 16'h005f}, '{16'h0054, 16'h003e, 16'h0050, 16'h1f90, 16'h003f}};
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 11; i++) begin
            // Secondary select values keep the reserved top bit clear.
            axi_wr(t[i][0][11:0], {24'h0, t[i][1][7:0]}, 4'hf, r); `CHK(r, 2'b00)
            axi_rd(t[i][0][11:0], d, r); `CHK(d, {24'h0, t[i][1][7:0]})
            core_chk(t[i][2], 1'b0, t[i][3], 1'b0);
            core_chk(t[i][4], 1'b1, t[i][4], 1'b0);
            if (t[i][0] == 16'h0050) `CHK(hold, t[i][1][7])
        end
        // Primary stays at the top while the secondary window sits below it.
        core_chk(16'h00f0, 1'b0, 16'h1fb0, 1'b0);
    endtask : test_windows

    // Zero word, unmapped index and a write without its low byte lane.
    task automatic test_zero_and_errors();
        logic [31:0] d;
        logic [1:0]  r;
        core_chk(16'h0000, 1'b0, 16'h0000, 1'b1);
        core_chk(16'h0000, 1'b1, 16'h0000, 1'b1);
        axi_wr(12'h000, 32'hffff_ffff, 4'hf, r);
        axi_rd(12'h000, d, r); `CHK(d, 32'h0)
        axi_rd(12'h100, d, r); `CHK(r, 2'b10)
        axi_wr(12'h100, 32'h11, 4'hf, r); `CHK(r, 2'b10)
        axi_wr(12'h054, 32'h11, 4'he, r);
        axi_rd(12'h054, d, r); `CHK(d, 32'h3e)
        // Status shows a 64-byte secondary window beside a 32-byte primary window.
        axi_rd(12'h080, d, r); `CHK(d, 32'h9)
        `CHK(r, 2'b00)
    endtask : test_zero_and_errors

    // ------------------------------------------------------------------
    // Sequence, verdict and watchdog
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset_state();
        test_windows();
        test_zero_and_errors();
        finish_test();
    end

    // The run takes well under a thousand cycles; five thousand means a hang.
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
endmodule : test_register_window_remapper
